/* cmc_defs.svh */
// Overview of operation
// - select low gives normal, high gives standby
// - normal mode: transmit low drives bus dominant
// - normal mode: receive output mirrors bus state
// - standby: transmitter, receiver off, detector watches
// - long standby dominant wakes, receive low later
// - wake not latched, released after recessive delay
// - unconditioned: dominant at entry wakes at once
// - conditioned: entry dominant ignored until released
// - split output enabled only in normal mode
// - overtemperature switches transmitter off, rest runs
// - thermal off clears when cool and transmit high
// - dominant timer starts on transmit falling edge
// - transmit low too long disables the transmitter
// - transmit rising edge resets timer and disable
// - floating transmit or select input reads high
`ifndef CMC_DEFS_SVH
`define CMC_DEFS_SVH

// sampling clock and durations in ns
`define CMC_CLK_NS        10
`define CMC_WAKE_FILT_NS  500
`define CMC_WAKE_VRFY_NS  1000
`define CMC_WAKE_REL_NS   500
`define CMC_DOM_TMO_NS    1000000
// least times: round up to whole cycles
`define CMC_CYC(t) (((t) + `CMC_CLK_NS - 1) / `CMC_CLK_NS)
`define CMC_WAKE_FILT_CYC `CMC_CYC(`CMC_WAKE_FILT_NS)
`define CMC_WAKE_VRFY_CYC `CMC_CYC(`CMC_WAKE_VRFY_NS)
`define CMC_WAKE_REL_CYC  `CMC_CYC(`CMC_WAKE_REL_NS)
`define CMC_DOM_TMO_CYC   `CMC_CYC(`CMC_DOM_TMO_NS)

// register byte offsets
`define CMC_OFF_CTRL      8'h00
`define CMC_OFF_STATE     8'h04
`define CMC_OFF_IRQ_STAT  8'h08
`define CMC_OFF_IRQ_EN    8'h0C
`define CMC_OFF_IRQ_CLR   8'h10

// field positions
`define CMC_CTRL_UNCOND   0
`define CMC_ST_STBY       0
`define CMC_ST_THERM      1
`define CMC_ST_TMO        2
`define CMC_ST_WAKE       3
`define CMC_ST_TXD        4
`define CMC_ST_BUS        5
`define CMC_IRQ_WAKE      0
`define CMC_IRQ_THERM     1
`define CMC_IRQ_TMO       2

// reset values
`define CMC_UNCOND_RST    1'b1
`define CMC_IRQ_RST       3'h0
`define CMC_WORD_RST      32'h0000_0000

`endif

/* cmc_pkg.sv */
package cmc_pkg;
   // standby wake detector states
   typedef enum logic [2:0] {
      WK_IDLE,
      WK_BLOCK,
      WK_FILTER,
      WK_VERIFY,
      WK_ACTIVE,
      WK_RELEASE
   } cmc_wake_type;
   // one bit per interrupt source
   typedef logic [2:0] cmc_irq_type;
endpackage

/* cmc_tmr_if.sv */
`timescale 1ns/1ps
`default_nettype none
// run request and expiry of one duration timer
interface cmc_tmr_if;
   logic run;
   logic done;
   modport owner (output run, input done);
   modport timer (input run, output done);
endinterface
`default_nettype wire

/* cmc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module cmc_sync #(
   parameter int               WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   // raw and synchronised levels
   input  wire logic [WIDTH-1:0] d_in,
   output logic      [WIDTH-1:0] q_out
);
   logic [WIDTH-1:0] meta_r;

   // two stages; only the second stage reads the first
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         meta_r <= RST_VAL;
         q_out  <= RST_VAL;
      end else begin
         meta_r <= d_in;
         q_out  <= meta_r;
      end
   end
endmodule
`default_nettype wire

/* cmc_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module cmc_timer #(
   parameter int LIMIT = 16
) (
   // clock and reset
   input  wire logic clk_in,
   input  wire logic rst_in,
   // run and expiry
   cmc_tmr_if.timer  tmr
);
   import cmc_pkg::*;
   localparam int           W   = $clog2(LIMIT + 1);
   localparam logic [W-1:0] LIM = W'(LIMIT);

   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;

   // count while run, park at limit, restart as soon as run drops
   assign cnt_nxt  = !tmr.run ? '0 :
                     (cnt_r == LIM) ? cnt_r : cnt_r + 1'b1;
   assign tmr.done = tmr.run && (cnt_r == LIM);

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
endmodule
`default_nettype wire

/* cmc_mode_ctrl.sv */
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cmc_defs.svh"
module cmc_mode_ctrl #(
   parameter int WAKE_FILT_CYC = `CMC_WAKE_FILT_CYC,
   parameter int WAKE_VRFY_CYC = `CMC_WAKE_VRFY_CYC,
   parameter int WAKE_REL_CYC  = `CMC_WAKE_REL_CYC,
   parameter int DOM_TMO_CYC   = `CMC_DOM_TMO_CYC
) (
   // clock and reset
   input  wire logic        CLOCK_IN,
   input  wire logic        SYS_RST_IN,
   // protocol controller side
   input  wire logic        TXD_IN,
   input  wire logic        TXD_FLOAT_IN,
   input  wire logic        STANDBY_SELECT_IN,
   input  wire logic        STANDBY_FLOAT_IN,
   output logic             RXD_OUT,
   // bus side
   input  wire logic        BUS_DOM_IN,
   input  wire logic        LP_BUS_DOM_IN,
   input  wire logic        OVERTEMP_IN,
   output logic             TX_DOMINANT_OUT,
   output logic             NORMAL_RX_EN_OUT,
   output logic             LP_DET_EN_OUT,
   output logic             SPLIT_EN_OUT,
   output logic             TXD_PULLUP_EN_OUT,
   output logic             STBY_PULLUP_EN_OUT,
   // apb slave
   input  wire logic        PSEL_IN,
   input  wire logic        PENABLE_IN,
   input  wire logic        PWRITE_IN,
   input  wire logic [7:0]  PADDR_IN,
   input  wire logic [31:0] PWDATA_IN,
   output logic      [31:0] PRDATA_OUT,
   output logic             PREADY_OUT,
   output logic             PSLVERR_OUT,
   // interrupt
   output logic             IRQ_OUT
);
   import cmc_pkg::*;

   // synchronised inputs
   logic [4:0]   raw_in;
   logic [4:0]   sync_q;
   logic         txd;
   logic         sel_sb;
   logic         bus_dom;
   logic         lp_dom;
   logic         hot;
   // mode and datapath state
   logic         mode_sb_r;
   logic         tx_r;
   logic         rx_r;
   logic         split_r;
   logic         rx_en_r;
   logic         stby_enter;
   logic         tx_nxt;
   logic         rx_nxt;
   // wake detector
   cmc_wake_type wk_r;
   cmc_wake_type wk_nxt;
   logic         wake_low;
   logic         wake_low_nxt;
   // thermal and dominant time-out
   logic         therm_r;
   logic         therm_nxt;
   logic         txd_prev_r;
   logic         txd_fall;
   logic         txd_rise;
   logic         low_run_r;
   logic         low_run_nxt;
   logic         tmo_r;
   logic         tmo_nxt;
   logic [2:0]   warm_r;
   // software visible
   logic         uncond_r;
   cmc_irq_type  irq_stat_r;
   cmc_irq_type  irq_en_r;
   cmc_irq_type  irq_ev;
   cmc_irq_type  irq_clr;
   cmc_irq_type  irq_stat_nxt;
   logic [31:0]  state_word;
   logic [31:0]  rd_mux;
   logic [31:0]  prdata_r;
   logic         slverr_r;
   logic         apb_setup;
   logic         apb_wr;
   logic         hit_ctrl;
   logic         hit_state;
   logic         hit_stat;
   logic         hit_en;
   logic         hit_clr;
   logic         hit_any;

   // timers
   cmc_tmr_if filt_if ();
   cmc_tmr_if vrfy_if ();
   cmc_tmr_if rel_if ();
   cmc_tmr_if dom_if ();

   // a floating pin is pulled high before it is sampled
   assign raw_in = {OVERTEMP_IN, LP_BUS_DOM_IN, BUS_DOM_IN,
                    STANDBY_SELECT_IN | STANDBY_FLOAT_IN,
                    TXD_IN | TXD_FLOAT_IN};

   // reset value: recessive transmit, standby selected
   cmc_sync #(.WIDTH(5), .RST_VAL(5'h03)) u_sync (
      .clk_in(CLOCK_IN), .rst_in(SYS_RST_IN), .d_in(raw_in),
      .q_out(sync_q));

   assign txd     = sync_q[0];
   assign sel_sb  = sync_q[1];
   assign bus_dom = sync_q[2];
   assign lp_dom  = sync_q[3];
   assign hot     = sync_q[4];

   cmc_timer #(.LIMIT(WAKE_FILT_CYC)) u_filt (
      .clk_in(CLOCK_IN), .rst_in(SYS_RST_IN), .tmr(filt_if));
   cmc_timer #(.LIMIT(WAKE_VRFY_CYC)) u_vrfy (
      .clk_in(CLOCK_IN), .rst_in(SYS_RST_IN), .tmr(vrfy_if));
   cmc_timer #(.LIMIT(WAKE_REL_CYC)) u_rel (
      .clk_in(CLOCK_IN), .rst_in(SYS_RST_IN), .tmr(rel_if));
   cmc_timer #(.LIMIT(DOM_TMO_CYC)) u_dom (
      .clk_in(CLOCK_IN), .rst_in(SYS_RST_IN), .tmr(dom_if));

   // timer run conditions
   assign filt_if.run = mode_sb_r && (wk_r == WK_FILTER) && lp_dom;
   assign vrfy_if.run = mode_sb_r && (wk_r == WK_VERIFY);
   assign rel_if.run  = mode_sb_r && (wk_r == WK_RELEASE) && !lp_dom;
   assign dom_if.run  = low_run_r && !txd;

   // mode entry and wake level
   assign stby_enter   = sel_sb && !mode_sb_r;
   assign wake_low     = (wk_r == WK_ACTIVE) || (wk_r == WK_RELEASE);
   assign wake_low_nxt = (wk_nxt == WK_ACTIVE) || (wk_nxt == WK_RELEASE);

   // wake detector; it sleeps in idle while the mode is normal
   always_comb begin
      wk_nxt = wk_r;
      if (!mode_sb_r) begin
         if (!stby_enter || !lp_dom) begin
            wk_nxt = WK_IDLE;
         end else if (uncond_r) begin
            wk_nxt = WK_ACTIVE;
         end else begin
            wk_nxt = WK_BLOCK;
         end
      end else begin
         unique case (wk_r)
            WK_IDLE: begin
               if (lp_dom) wk_nxt = WK_FILTER;
            end
            WK_BLOCK: begin
               if (!lp_dom) wk_nxt = WK_IDLE;
            end
            WK_FILTER: begin
               if (!lp_dom) begin
                  wk_nxt = WK_IDLE;
               end else if (filt_if.done) begin
                  wk_nxt = WK_VERIFY;
               end
            end
            WK_VERIFY: begin
               if (vrfy_if.done) wk_nxt = WK_ACTIVE;
            end
            WK_ACTIVE: begin
               if (!lp_dom) wk_nxt = WK_RELEASE;
            end
            WK_RELEASE: begin
               if (lp_dom) begin
                  wk_nxt = WK_ACTIVE;
               end else if (rel_if.done) begin
                  wk_nxt = WK_IDLE;
               end
            end
            default: begin
               wk_nxt = WK_IDLE;
            end
         endcase
      end
   end

   // transmit path: any protection or standby forces recessive
   assign tx_nxt = !mode_sb_r && !txd && !therm_r && !tmo_r;
   assign rx_nxt = mode_sb_r ? !wake_low : !bus_dom;

   // thermal latch; overtemperature wins over the release
   assign therm_nxt = hot || (therm_r && !txd);

   // dominant time-out, armed by a falling edge only; until the
   // synchroniser is flushed after reset its reset level could fake one
   assign txd_fall    = warm_r[2] && txd_prev_r && !txd;
   assign txd_rise    = !txd_prev_r && txd;
   assign low_run_nxt = txd_fall ? 1'b1 : (txd_rise ? 1'b0 : low_run_r);
   assign tmo_nxt     = txd_rise ? 1'b0 : (tmo_r || dom_if.done);

   // mode and pin outputs, all registered
   always_ff @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         mode_sb_r <= 1'b1;
         tx_r      <= 1'b0;
         rx_r      <= 1'b1;
         split_r   <= 1'b0;
         rx_en_r   <= 1'b0;
         wk_r      <= WK_IDLE;
      end else begin
         mode_sb_r <= sel_sb;
         tx_r      <= tx_nxt;
         rx_r      <= rx_nxt;
         split_r   <= !sel_sb;
         rx_en_r   <= !sel_sb;
         wk_r      <= wk_nxt;
      end
   end

   // protection state
   always_ff @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         therm_r    <= 1'b0;
         txd_prev_r <= 1'b1;
         low_run_r  <= 1'b0;
         tmo_r      <= 1'b0;
         warm_r     <= 3'h0;
      end else begin
         warm_r     <= {warm_r[1:0], 1'b1};
         therm_r    <= therm_nxt;
         txd_prev_r <= txd;
         low_run_r  <= low_run_nxt;
         tmo_r      <= tmo_nxt;
      end
   end

   assign TX_DOMINANT_OUT    = tx_r;
   assign RXD_OUT            = rx_r;
   assign SPLIT_EN_OUT       = split_r;
   assign NORMAL_RX_EN_OUT   = rx_en_r;
   assign LP_DET_EN_OUT      = mode_sb_r;
   // pull-ups are always on, so a cut wire reads high
   assign TXD_PULLUP_EN_OUT  = 1'b1;
   assign STBY_PULLUP_EN_OUT = 1'b1;

   // apb decode; zero wait states, so pready is tied high
   assign apb_setup = PSEL_IN && !PENABLE_IN;
   assign apb_wr    = PSEL_IN && PENABLE_IN && PWRITE_IN;
   assign hit_ctrl  = (PADDR_IN == `CMC_OFF_CTRL);
   assign hit_state = (PADDR_IN == `CMC_OFF_STATE);
   assign hit_stat  = (PADDR_IN == `CMC_OFF_IRQ_STAT);
   assign hit_en    = (PADDR_IN == `CMC_OFF_IRQ_EN);
   assign hit_clr   = (PADDR_IN == `CMC_OFF_IRQ_CLR);
   assign hit_any   = hit_ctrl || hit_state || hit_stat || hit_en || hit_clr;

   // live state word
   always_comb begin
      state_word                = `CMC_WORD_RST;
      state_word[`CMC_ST_STBY]  = mode_sb_r;
      state_word[`CMC_ST_THERM] = therm_r;
      state_word[`CMC_ST_TMO]   = tmo_r;
      state_word[`CMC_ST_WAKE]  = wake_low;
      state_word[`CMC_ST_TXD]   = txd;
      state_word[`CMC_ST_BUS]   = bus_dom;
   end

   // read select; the clear register reads as zero
   assign rd_mux = hit_ctrl  ? {31'h0000_0000, uncond_r} :
                   hit_state ? state_word :
                   hit_stat  ? {29'h0000_0000, irq_stat_r} :
                   hit_en    ? {29'h0000_0000, irq_en_r} :
                   `CMC_WORD_RST;

   // events; a set in the same cycle as its clear survives
   assign irq_ev[`CMC_IRQ_WAKE]  = wake_low_nxt && !wake_low;
   assign irq_ev[`CMC_IRQ_THERM] = hot && !therm_r;
   assign irq_ev[`CMC_IRQ_TMO]   = dom_if.done && !tmo_r;
   assign irq_clr      = (apb_wr && hit_clr) ? PWDATA_IN[2:0] : `CMC_IRQ_RST;
   assign irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_ev;

   // read data is caught in setup; it may lag live state by one cycle
   always_ff @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         prdata_r <= `CMC_WORD_RST;
         slverr_r <= 1'b0;
      end else if (apb_setup) begin
         prdata_r <= rd_mux;
         slverr_r <= !hit_any;
      end
   end

   // software registers
   always_ff @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         uncond_r   <= `CMC_UNCOND_RST;
         irq_en_r   <= `CMC_IRQ_RST;
         irq_stat_r <= `CMC_IRQ_RST;
      end else begin
         if (apb_wr && hit_ctrl) uncond_r <= PWDATA_IN[`CMC_CTRL_UNCOND];
         if (apb_wr && hit_en) irq_en_r <= PWDATA_IN[2:0];
         irq_stat_r <= irq_stat_nxt;
      end
   end

   assign PRDATA_OUT  = prdata_r;
   assign PSLVERR_OUT = slverr_r;
   assign PREADY_OUT  = 1'b1;
   assign IRQ_OUT     = |(irq_stat_r & irq_en_r);

   // checks
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (SYS_RST_IN);

   sequence s_wake_verified;
      mode_sb_r && (wk_r == WK_VERIFY) && vrfy_if.done ##1 mode_sb_r;
   endsequence
   sequence s_wake_released;
      mode_sb_r && (wk_r == WK_RELEASE) && rel_if.done ##1 mode_sb_r;
   endsequence

   a_mode_select: assert property (
      sel_sb ##1 sel_sb |-> mode_sb_r && LP_DET_EN_OUT && !NORMAL_RX_EN_OUT)
      else $error("standby select not followed");
   a_tx_normal: assert property (
      !mode_sb_r && !txd && !therm_r && !tmo_r |=> TX_DOMINANT_OUT)
      else $error("transmit low did not drive dominant");
   a_rx_mirror: assert property (
      !mode_sb_r |=> (RXD_OUT == !$past(bus_dom)))
      else $error("receive output does not mirror bus");
   a_stby_tx_off: assert property (
      mode_sb_r |=> !TX_DOMINANT_OUT)
      else $error("transmitter active in standby");
   a_short_reject: assert property (
      mode_sb_r && (wk_r == WK_FILTER) && !lp_dom |=> wk_r == WK_IDLE)
      else $error("short dominant accepted as wake");
   a_wake_drive: assert property (
      s_wake_verified |=> !RXD_OUT)
      else $error("receive not low after verified wake");
   a_wake_return: assert property (
      s_wake_released |=> RXD_OUT)
      else $error("receive not high after wake release");
   a_uncond_entry: assert property (
      stby_enter && lp_dom && uncond_r |=> wk_r == WK_ACTIVE ##1 !RXD_OUT)
      else $error("unconditioned entry did not wake");
   a_block_entry: assert property (
      stby_enter && lp_dom && !uncond_r ##1 mode_sb_r && lp_dom
      |=> wk_r == WK_BLOCK && RXD_OUT)
      else $error("entry dominant not ignored");
   a_split_off: assert property (
      mode_sb_r |-> !SPLIT_EN_OUT)
      else $error("split enabled in standby");
   a_therm_off: assert property (
      hot |=> therm_r ##1 !TX_DOMINANT_OUT)
      else $error("transmitter not off when hot");
   a_therm_hold: assert property (
      therm_r && (!txd || hot) |=> therm_r)
      else $error("thermal off released early");
   a_tmo_trip: assert property (
      dom_if.done && !txd_rise |=> tmo_r ##1 !TX_DOMINANT_OUT)
      else $error("dominant time-out did not disable");
   a_rise_clear: assert property (
      txd_rise |=> !tmo_r && !dom_if.done)
      else $error("rising edge did not reset time-out");
   a_arm_fall: assert property (
      txd_fall |=> low_run_r)
      else $error("falling edge did not start timer");
   a_irq_level: assert property (
      (irq_stat_r & irq_en_r) != 3'h0 |-> IRQ_OUT)
      else $error("enabled status without interrupt");
endmodule
`default_nettype wire

/* cmc_ctl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cmc_ctl_model #(
   parameter int BIT_MIN_CYC = 100,
   parameter int BIT_MAX_CYC = 2500
) (
   // clock
   input  wire logic clk_in,
   // transmit and select pins
   output logic      txd_out,
   output logic      txd_float_out,
   output logic      stby_out,
   output logic      stby_float_out
);
   // power-up: recessive, standby, pins attached
   initial begin
      txd_out        = 1'b1;
      txd_float_out  = 1'b0;
      stby_out       = 1'b1;
      stby_float_out = 1'b0;
   end
   // pin levels change only just after an edge
   task automatic drive(input logic txd, input logic stby);
      @(posedge clk_in);
      txd_out  <= txd;
      stby_out <= stby;
   endtask
   // detach pins; level left as commanded, to prove the float path
   task automatic detach(input logic tf, input logic sf);
      @(posedge clk_in);
      txd_float_out  <= tf;
      stby_float_out <= sf;
   endtask
   // eight bits msb first, bit time clamped to the legal rates
   task automatic send(input logic [7:0] bits, input int bit_cyc);
      int cyc;
      cyc = (bit_cyc < BIT_MIN_CYC) ? BIT_MIN_CYC : bit_cyc;
      cyc = (cyc > BIT_MAX_CYC) ? BIT_MAX_CYC : cyc;
      for (int i = 7; i >= 0; i--) begin
         @(posedge clk_in);
         txd_out <= bits[i];
         repeat (cyc - 1) @(posedge clk_in);
      end
      @(posedge clk_in);
      txd_out <= 1'b1;
   endtask
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cmc_defs.svh"
module tb_top;
   // shortened durations keep the run brief
   localparam int FILT = 4;
   localparam int VRFY = 6;
   localparam int REL  = 3;
   localparam int TMO  = 20;
   logic             clk, rst, bus_dom, lp_dom, hot;
   logic             psel, penable, pwrite, err;
   logic [7:0]       paddr;
   logic [31:0]      pwdata, rdata;
   int               num_errors, total_checks, n;
   wire logic        txd, txd_fl, stby, stby_fl, rxd, tx_dom, rx_en;
   wire logic        lp_en, split_en, txd_pu, stby_pu, pready, pslverr;
   wire logic        irq;
   wire logic [31:0] prdata;

   // bit time of 3 keeps a six-bit dominant run under the time-out
   cmc_ctl_model #(.BIT_MIN_CYC(2), .BIT_MAX_CYC(3)) ctl (
      .clk_in(clk), .txd_out(txd), .txd_float_out(txd_fl),
      .stby_out(stby), .stby_float_out(stby_fl));
   cmc_mode_ctrl #(.WAKE_FILT_CYC(FILT), .WAKE_VRFY_CYC(VRFY),
      .WAKE_REL_CYC(REL), .DOM_TMO_CYC(TMO)) dut (
      .CLOCK_IN(clk), .SYS_RST_IN(rst), .TXD_IN(txd),
      .TXD_FLOAT_IN(txd_fl), .STANDBY_SELECT_IN(stby),
      .STANDBY_FLOAT_IN(stby_fl), .RXD_OUT(rxd), .BUS_DOM_IN(bus_dom),
      .LP_BUS_DOM_IN(lp_dom), .OVERTEMP_IN(hot), .TX_DOMINANT_OUT(tx_dom),
      .NORMAL_RX_EN_OUT(rx_en), .LP_DET_EN_OUT(lp_en),
      .SPLIT_EN_OUT(split_en), .TXD_PULLUP_EN_OUT(txd_pu),
      .STBY_PULLUP_EN_OUT(stby_pu), .PSEL_IN(psel), .PENABLE_IN(penable),
      .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
      .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
      .IRQ_OUT(irq));

   // compare and count; an unknown never matches
   task automatic chk(input string s, input logic [31:0] e,
                      input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", s, e, g);
      end
   endtask
   task automatic chk1(input string s, input logic e, input logic g);
      chk(s, {31'h0, e}, {31'h0, g});
   endtask
   // wait whole cycles, then let the edge's updates land
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic pins(input logic b, input logic l, input logic h);
      @(posedge clk);
      bus_dom <= b;
      lp_dom  <= l;
      hot     <= h;
   endtask
   // one transfer: setup, then access held until ready is seen
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      chk1("pready", 1'b1, pready);
      rdata = prdata;
      err   = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      chk1("pslverr", 1'b0, err);
   endtask
   task automatic rdb(input logic [7:0] a, input int b, input logic e);
      apb(1'b0, a, 32'h0);
      chk1("register bit", e, rdata[b]);
   endtask
   // bounded wait on the receive pin; n gives the cycles taken
   task automatic wait_rx(input logic v);
      n = 0;
      while (rxd !== v && n < 40) begin
         tick(1);
         n++;
      end
      chk1("rxd", v, rxd);
   endtask
   // normal mode on a dominant bus, then into standby
   task automatic enter_dom();
      ctl.drive(1'b1, 1'b0);
      pins(1'b1, 1'b1, 1'b0);
      tick(4);
      ctl.drive(1'b1, 1'b1);
   endtask
   task automatic complete_run();
      $display("checks %0d, errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // free-running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // a hang costs an error, then the normal close
   initial begin
      repeat (5000) @(posedge clk);
      num_errors++;
      complete_run();
   end
   // test sequence
   initial begin
      {rst, bus_dom, lp_dom, hot, psel, penable, pwrite} = 7'h40;
      paddr = 8'h00;
      pwdata = 32'h0;
      num_errors = 0;
      total_checks = 0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk1("rxd", 1'b1, rxd);
      chk1("tx_dom", 1'b0, tx_dom);
      chk1("lp_en", 1'b1, lp_en);
      chk1("split", 1'b0, split_en);
      chk1("irq", 1'b0, irq);
      chk1("txd pullup", 1'b1, txd_pu);
      chk1("select pullup", 1'b1, stby_pu);
      apb(1'b0, `CMC_OFF_CTRL, 32'h0);
      chk("ctrl", 32'h0000_0001, rdata);
      apb(1'b1, 8'h20, 32'hFFFF_FFFF);
      chk1("pslverr", 1'b1, err);
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped", 32'h0, rdata);
      wr(`CMC_OFF_IRQ_EN, 32'h0000_0007);
      apb(1'b0, `CMC_OFF_IRQ_EN, 32'h0);
      chk("irq_en", 32'h0000_0007, rdata);
      // normal mode: follow transmit and bus
      ctl.drive(1'b1, 1'b0);
      tick(4);
      chk1("rx_en", 1'b1, rx_en);
      chk1("lp_en", 1'b0, lp_en);
      chk1("split", 1'b1, split_en);
      ctl.drive(1'b0, 1'b0);
      tick(4);
      chk1("tx_dom", 1'b1, tx_dom);
      pins(1'b1, 1'b0, 1'b0);
      tick(4);
      chk1("rxd", 1'b0, rxd);
      ctl.drive(1'b1, 1'b0);
      pins(1'b0, 1'b0, 1'b0);
      tick(4);
      chk1("tx_dom", 1'b0, tx_dom);
      chk1("rxd", 1'b1, rxd);
      ctl.send(8'h81, 3);
      tick(4);
      rdb(`CMC_OFF_STATE, `CMC_ST_TMO, 1'b0);
      // stuck-low transmit trips the time-out
      ctl.drive(1'b0, 1'b0);
      tick(4);
      chk1("tx_dom", 1'b1, tx_dom);
      tick(TMO - 4);
      chk1("tx_dom", 1'b1, tx_dom);
      tick(8);
      chk1("tx_dom", 1'b0, tx_dom);
      chk1("irq", 1'b1, irq);
      rdb(`CMC_OFF_IRQ_STAT, `CMC_IRQ_TMO, 1'b1);
      wr(`CMC_OFF_IRQ_CLR, 32'h0000_0004);
      rdb(`CMC_OFF_IRQ_STAT, `CMC_IRQ_TMO, 1'b0);
      chk1("irq", 1'b0, irq);
      ctl.drive(1'b1, 1'b0);
      tick(4);
      rdb(`CMC_OFF_STATE, `CMC_ST_TMO, 1'b0);
      ctl.drive(1'b0, 1'b0);
      tick(4);
      chk1("tx_dom", 1'b1, tx_dom);
      // overheating: transmitter off, receiver still working
      pins(1'b1, 1'b0, 1'b1);
      tick(5);
      chk1("tx_dom", 1'b0, tx_dom);
      chk1("rxd", 1'b0, rxd);
      pins(1'b0, 1'b0, 1'b0);
      tick(4);
      chk1("tx_dom", 1'b0, tx_dom);
      ctl.drive(1'b1, 1'b0);
      tick(4);
      rdb(`CMC_OFF_STATE, `CMC_ST_THERM, 1'b0);
      rdb(`CMC_OFF_IRQ_STAT, `CMC_IRQ_THERM, 1'b1);
      ctl.drive(1'b0, 1'b0);
      tick(4);
      chk1("tx_dom", 1'b1, tx_dom);
      // standby ignores transmit and the normal receiver
      ctl.drive(1'b0, 1'b1);
      pins(1'b1, 1'b0, 1'b0);
      tick(4);
      chk1("tx_dom", 1'b0, tx_dom);
      chk1("rx_en", 1'b0, rx_en);
      chk1("lp_en", 1'b1, lp_en);
      chk1("split", 1'b0, split_en);
      chk1("rxd", 1'b1, rxd);
      ctl.drive(1'b1, 1'b1);
      // short dominant filtered, long one wakes, release unlatched
      pins(1'b0, 1'b1, 1'b0);
      tick(2);
      pins(1'b0, 1'b0, 1'b0);
      tick(20);
      chk1("rxd", 1'b1, rxd);
      pins(1'b0, 1'b1, 1'b0);
      wait_rx(1'b0);
      chk1("wake delay", 1'b1, n >= FILT + VRFY);
      rdb(`CMC_OFF_IRQ_STAT, `CMC_IRQ_WAKE, 1'b1);
      pins(1'b0, 1'b0, 1'b0);
      wait_rx(1'b1);
      chk1("release delay", 1'b1, n >= REL);
      // standby entered over a stuck dominant, both versions
      enter_dom();
      tick(6);
      chk1("rxd", 1'b0, rxd);
      pins(1'b0, 1'b0, 1'b0);
      wait_rx(1'b1);
      wr(`CMC_OFF_CTRL, 32'h0);
      enter_dom();
      tick(30);
      chk1("rxd", 1'b1, rxd);
      pins(1'b0, 1'b0, 1'b0);
      tick(10);
      pins(1'b0, 1'b1, 1'b0);
      wait_rx(1'b0);
      chk1("wake delay", 1'b1, n >= FILT + VRFY);
      pins(1'b0, 1'b0, 1'b0);
      wait_rx(1'b1);
      // detached pins read high
      ctl.drive(1'b0, 1'b0);
      ctl.detach(1'b1, 1'b0);
      tick(5);
      chk1("tx_dom", 1'b0, tx_dom);
      rdb(`CMC_OFF_STATE, `CMC_ST_TXD, 1'b1);
      ctl.detach(1'b0, 1'b1);
      tick(5);
      chk1("lp_en", 1'b1, lp_en);
      ctl.detach(1'b0, 1'b0);
      // mask hides sticky status; clear empties it
      wr(`CMC_OFF_IRQ_EN, 32'h0);
      tick(0);
      chk1("irq", 1'b0, irq);
      wr(`CMC_OFF_IRQ_EN, 32'h0000_0007);
      tick(0);
      chk1("irq", 1'b1, irq);
      wr(`CMC_OFF_IRQ_CLR, 32'h0000_0007);
      tick(0);
      chk1("irq", 1'b0, irq);
      // reset mid-run with transmit low: timers cleared, no trip
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      tick(TMO + 10);
      chk1("tx_dom", 1'b1, tx_dom);
      rdb(`CMC_OFF_STATE, `CMC_ST_TMO, 1'b0);
      apb(1'b0, `CMC_OFF_IRQ_STAT, 32'h0);
      chk("irq_stat", 32'h0, rdata);
      ctl.drive(1'b1, 1'b0);
      tick(4);
      complete_run();
   end
endmodule
`default_nettype wire
